// file: host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model(
	input wire logic clk,
	input wire logic [15:0] ioRdData_ff,
	output logic [15:0] ioAddr,
	output logic [15:0] ioWrData,
	output logic ioWr,
	output logic ioRd
);
	initial begin
		ioAddr = 16'h0000;
		ioWrData = 16'h0000;
		ioWr = 1'b0;
		ioRd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// idle address and data are inverted so a stale value is never trusted
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		ioAddr = a;
		ioWrData = d;
		ioWr = 1'b1;
		@(negedge clk);
		ioWr = 1'b0;
		ioAddr = ~a;
		ioWrData = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		ioAddr = a;
		ioRd = 1'b1;
		@(negedge clk);
		ioRd = 1'b0;
		ioAddr = ~a;
		d = ioRdData_ff;
	endtask
endmodule

// file: mix_unit.sv
`timescale 1ns/1ps
module mix_unit(
	input wire logic rop,
	input wire logic [7:0] ropCode,
	input wire pixel_mix_pkg::mix_type fgMix,
	input wire pixel_mix_pkg::mix_type bgMix,
	input wire logic [7:0] useFg,
	input wire logic [63:0] fgRep,
	input wire logic [63:0] bgRep,
	input wire logic [63:0] cpuData,
	input wire logic [63:0] srcData,
	input wire logic [63:0] patData,
	input wire logic [63:0] dst,
	output wire logic [63:0] newColor
);
	import pixel_mix_pkg::*;

	function automatic logic [7:0] mixByte(input logic [3:0] op,
		input logic [7:0] s, input logic [7:0] d);
		unique case (op)
			4'h0: return ~d;
			4'h1: return 8'h00;
			4'h2: return 8'hFF;
			4'h3: return d;
			4'h4: return ~s;
			4'h5: return s ^ d;
			4'h6: return ~(s ^ d);
			4'h7: return s;
			4'h8: return ~s | ~d;
			4'h9: return d | ~s;
			4'hA: return s | ~d;
			4'hB: return s | d;
			4'hC: return s & d;
			4'hD: return ~s & d;
			4'hE: return s & ~d;
			4'hF: return ~s & ~d;
		endcase
	endfunction

	genvar j;
	for (j = 0; j < 8; j++) begin : g_lane
		mix_type m;
		logic [7:0] s;
		logic [7:0] ropOut;
		always_comb begin
			m = useFg[j] ? fgMix : bgMix;
			unique case (m.src)
				SRC_BG: s = bgRep[8*j+:8];
				SRC_FG: s = fgRep[8*j+:8];
				SRC_CPU: s = cpuData[8*j+:8];
				SRC_BMP: s = dst[8*j+:8];
			endcase
			// pattern, source, destination index the 8-entry truth table
			for (int b = 0; b < 8; b++) begin
				ropOut[b] = ropCode[{patData[8*j+b], srcData[8*j+b],
					dst[8*j+b]}];
			end
		end
		assign newColor[8*j+:8] = rop ? ropOut : mixByte(m.op, s,
			dst[8*j+:8]);
	end
endmodule

// file: pixel_gate.sv
`timescale 1ns/1ps
module pixel_gate(
	input wire pixel_mix_pkg::pix_size_type size,
	input wire logic [63:0] newColor,
	input wire logic [63:0] cmpRep,
	input wire logic [63:0] wrRep,
	input wire logic cmpEn,
	input wire logic cmpSense,
	input wire logic [7:0] clipOk,
	output wire logic [63:0] bitEn
);
	import pixel_mix_pkg::*;

	logic [7:0] eq;
	logic [7:0] pass;
	logic [7:0] ok;

	always_comb begin
		for (int j = 0; j < 8; j++) begin
			eq[j] = newColor[8*j+:8] == cmpRep[8*j+:8];
		end
		// a pixel matches only when every lane of it matches
		pass = grpAll(eq, size);
		if (!cmpEn) begin
			pass = 8'hFF;
		end else if (!cmpSense) begin
			pass = ~pass;
		end
		ok = pass & clipOk;
	end

	genvar j;
	for (j = 0; j < 8; j++) begin : g_en
		assign bitEn[8*j+:8] = {8{ok[j]}} & wrRep[8*j+:8];
	end
endmodule

// file: pixel_mix_pkg.sv
package pixel_mix_pkg;
	localparam logic [15:0] BG_COLOR_ADDR = 16'hA2E8;
	localparam logic [15:0] FG_COLOR_ADDR = 16'hA6E8;
	localparam logic [15:0] WR_MASK_ADDR = 16'hAAE8;
	localparam logic [15:0] RD_MASK_ADDR = 16'hAEE8;
	localparam logic [15:0] CMP_COLOR_ADDR = 16'hB2E8;
	localparam logic [15:0] BG_MIX_ADDR = 16'hB6E8;
	localparam logic [15:0] FG_MIX_ADDR = 16'hBAE8;
	localparam logic [15:0] MULTI_ADDR = 16'hBEE8;
	localparam logic [15:0] ROP_MIX_ADDR = 16'hD2E8;
	localparam logic [15:0] XFER_LO_ADDR = 16'hE2E8;
	localparam logic [15:0] XFER_HI_ADDR = 16'hE2EA;
	localparam logic [3:0] IDX_CLIP_TOP = 4'h1;
	localparam logic [3:0] IDX_CLIP_LEFT = 4'h2;
	localparam logic [3:0] IDX_CLIP_BOT = 4'h3;
	localparam logic [3:0] IDX_CLIP_RIGHT = 4'h4;
	localparam logic [3:0] IDX_PIXCTL = 4'hA;
	localparam logic [3:0] IDX_MISC = 4'hE;
	localparam int IDX_LSB = 12;
	localparam int MIX_OP_LSB = 0;
	localparam int MIX_SRC_LSB = 5;
	localparam int MASK_SRC_LSB = 6;
	localparam int CMP_SENSE_BIT = 7;
	localparam int CMP_EN_BIT = 8;
	localparam int EXT_CLIP_BIT = 5;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] ALL_PLANES = 16'hFFFF;
	localparam logic [11:0] CLIP_LOW_RESET = 12'h000;
	localparam logic [11:0] CLIP_HIGH_RESET = 12'hFFF;
	localparam logic [7:0] ROP_RESET = 8'h00;
	localparam logic [3:0] MIX_NEW = 4'h7;
	localparam logic [2:0] XFER_WORDS = 3'h4;
	localparam logic [2:0] MASK_WORDS = 3'h1;

	typedef enum logic [1:0] {SRC_BG, SRC_FG, SRC_CPU, SRC_BMP} color_src_type;
	typedef enum logic [1:0] {MSK_ONE, MSK_RSV, MSK_CPU, MSK_BMP} mask_src_type;
	typedef enum logic [1:0] {PIX8, PIX16, PIX32} pix_size_type;
	typedef struct packed {
		logic [3:0] op;
		color_src_type src;
	} mix_type;
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		pix_size_type size;
		logic rop;
		logic srcCpu;
		logic srcMono;
		logic patMono;
		logic [63:0] dst;
		logic [63:0] pat;
		logic [63:0] bmpSrc;
	} step_type;

	function automatic logic [1:0] sizeShift(input pix_size_type s);
		unique case (s)
			PIX8: return 2'd0;
			PIX16: return 2'd1;
			default: return 2'd2;
		endcase
	endfunction

	// 32-bit pixels take the 16-bit colour in the low half only
	function automatic logic [63:0] repColor(input logic [15:0] c,
		input pix_size_type s);
		unique case (s)
			PIX8: return {8{c[7:0]}};
			PIX16: return {4{c}};
			default: return {2{16'h0000, c}};
		endcase
	endfunction

	function automatic logic [7:0] pixToLane(input logic [7:0] b,
		input pix_size_type s);
		logic [7:0] r;
		r = 8'h00;
		for (int j = 0; j < 8; j++) begin
			r[j] = b[3'(j) >> sizeShift(s)];
		end
		return r;
	endfunction

	function automatic logic [7:0] grpAll(input logic [7:0] e,
		input pix_size_type s);
		logic [7:0] r;
		r = 8'hFF;
		for (int j = 0; j < 8; j++) begin
			for (int k = 0; k < 8; k++) begin
				if ((3'(k) >> sizeShift(s)) == (3'(j) >> sizeShift(s))) begin
					r[j] = r[j] & e[k];
				end
			end
		end
		return r;
	endfunction

	function automatic logic [63:0] laneSel(input logic [7:0] sel,
		input logic [63:0] a, input logic [63:0] b);
		logic [63:0] r;
		r = b;
		for (int j = 0; j < 8; j++) begin
			if (sel[j]) begin
				r[8*j+:8] = a[8*j+:8];
			end
		end
		return r;
	endfunction

	function automatic logic isXfer(input logic [15:0] a);
		return (a == XFER_LO_ADDR) || (a == XFER_HI_ADDR);
	endfunction
endpackage

// file: pixel_update_mix_unit.sv
`timescale 1ns/1ps
module pixel_update_mix_unit(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] ioAddr,
	input wire logic [15:0] ioWrData,
	input wire logic ioWr,
	input wire logic ioRd,
	output logic [15:0] ioRdData_ff,
	input wire pixel_mix_pkg::step_type step,
	input wire logic stepValid,
	output logic stepDone_ff,
	output logic memValid_ff,
	output logic [63:0] memData_ff,
	output logic [63:0] memBitEn_ff,
	output logic xferFull_ff
);
	import pixel_mix_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] bgColor_ff, nxt_bgColor, fgColor_ff, nxt_fgColor;
	logic [15:0] wrMask_ff, nxt_wrMask, rdMask_ff, nxt_rdMask;
	logic [15:0] cmpColor_ff, nxt_cmpColor;
	logic [15:0] bgMix_ff, nxt_bgMix, fgMix_ff, nxt_fgMix;
	logic [15:0] pixCtl_ff, nxt_pixCtl, misc_ff, nxt_misc;
	logic [11:0] clipTop_ff, nxt_clipTop, clipLeft_ff, nxt_clipLeft;
	logic [11:0] clipBot_ff, nxt_clipBot, clipRight_ff, nxt_clipRight;
	logic [7:0] ropMix_ff, nxt_ropMix;
	logic [15:0] nxt_rdData;

	always_comb begin
		nxt_bgColor = bgColor_ff;
		nxt_fgColor = fgColor_ff;
		nxt_wrMask = wrMask_ff;
		nxt_rdMask = rdMask_ff;
		nxt_cmpColor = cmpColor_ff;
		nxt_bgMix = bgMix_ff;
		nxt_fgMix = fgMix_ff;
		nxt_pixCtl = pixCtl_ff;
		nxt_misc = misc_ff;
		nxt_clipTop = clipTop_ff;
		nxt_clipLeft = clipLeft_ff;
		nxt_clipBot = clipBot_ff;
		nxt_clipRight = clipRight_ff;
		nxt_ropMix = ropMix_ff;
		nxt_rdData = ioRdData_ff;
		if (ioWr) begin
			case (ioAddr)
				BG_COLOR_ADDR: nxt_bgColor = ioWrData;
				FG_COLOR_ADDR: nxt_fgColor = ioWrData;
				WR_MASK_ADDR: nxt_wrMask = ioWrData;
				RD_MASK_ADDR: nxt_rdMask = ioWrData;
				CMP_COLOR_ADDR: nxt_cmpColor = ioWrData;
				BG_MIX_ADDR: nxt_bgMix = ioWrData;
				FG_MIX_ADDR: nxt_fgMix = ioWrData;
				ROP_MIX_ADDR: nxt_ropMix = ioWrData[7:0];
				MULTI_ADDR: begin
					// index in the top nibble steers the shared port
					case (ioWrData[15:IDX_LSB])
						IDX_CLIP_TOP: nxt_clipTop = ioWrData[11:0];
						IDX_CLIP_LEFT: nxt_clipLeft = ioWrData[11:0];
						IDX_CLIP_BOT: nxt_clipBot = ioWrData[11:0];
						IDX_CLIP_RIGHT: nxt_clipRight = ioWrData[11:0];
						IDX_PIXCTL: nxt_pixCtl = ioWrData;
						IDX_MISC: nxt_misc = ioWrData;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		if (ioRd) begin
			case (ioAddr)
				BG_COLOR_ADDR: nxt_rdData = bgColor_ff;
				FG_COLOR_ADDR: nxt_rdData = fgColor_ff;
				WR_MASK_ADDR: nxt_rdData = wrMask_ff;
				RD_MASK_ADDR: nxt_rdData = rdMask_ff;
				CMP_COLOR_ADDR: nxt_rdData = cmpColor_ff;
				BG_MIX_ADDR: nxt_rdData = bgMix_ff;
				FG_MIX_ADDR: nxt_rdData = fgMix_ff;
				ROP_MIX_ADDR: nxt_rdData = {8'h00, ropMix_ff};
				MULTI_ADDR: nxt_rdData = misc_ff;
				default: nxt_rdData = REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bgColor_ff <= REG_RESET;
			fgColor_ff <= REG_RESET;
			wrMask_ff <= ALL_PLANES;
			rdMask_ff <= ALL_PLANES;
			cmpColor_ff <= REG_RESET;
			bgMix_ff <= REG_RESET;
			fgMix_ff <= REG_RESET;
			pixCtl_ff <= REG_RESET;
			misc_ff <= REG_RESET;
			clipTop_ff <= CLIP_LOW_RESET;
			clipLeft_ff <= CLIP_LOW_RESET;
			clipBot_ff <= CLIP_HIGH_RESET;
			clipRight_ff <= CLIP_HIGH_RESET;
			ropMix_ff <= ROP_RESET;
			ioRdData_ff <= REG_RESET;
		end else begin
			bgColor_ff <= nxt_bgColor;
			fgColor_ff <= nxt_fgColor;
			wrMask_ff <= nxt_wrMask;
			rdMask_ff <= nxt_rdMask;
			cmpColor_ff <= nxt_cmpColor;
			bgMix_ff <= nxt_bgMix;
			fgMix_ff <= nxt_fgMix;
			pixCtl_ff <= nxt_pixCtl;
			misc_ff <= nxt_misc;
			clipTop_ff <= nxt_clipTop;
			clipLeft_ff <= nxt_clipLeft;
			clipBot_ff <= nxt_clipBot;
			clipRight_ff <= nxt_clipRight;
			ropMix_ff <= nxt_ropMix;
			ioRdData_ff <= nxt_rdData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	mix_type fgMix, bgMix;
	mask_src_type maskSrc;
	logic [63:0] fgRep, bgRep, cmpRep, wrRep, rdRep;
	logic [63:0] cpuBuf_ff, nxt_cpuBuf, srcColor, srcData, patData;
	logic [2:0] cpuWords_ff, nxt_cpuWords, needWords;
	logic colorCpu, dataOk, take;
	logic [7:0] allOnes, useFg, clipPix, clipLane;
	logic [63:0] newColor, bitEn;

	always_comb begin
		fgMix = '{fgMix_ff[MIX_OP_LSB+:4],
			color_src_type'(fgMix_ff[MIX_SRC_LSB+:2])};
		bgMix = '{bgMix_ff[MIX_OP_LSB+:4],
			color_src_type'(bgMix_ff[MIX_SRC_LSB+:2])};
		maskSrc = mask_src_type'(pixCtl_ff[MASK_SRC_LSB+:2]);
		fgRep = repColor(fgColor_ff, step.size);
		bgRep = repColor(bgColor_ff, step.size);
		cmpRep = repColor(cmpColor_ff, step.size);
		wrRep = repColor(wrMask_ff, step.size);
		rdRep = repColor(rdMask_ff, step.size);
		for (int j = 0; j < 8; j++) begin
			allOnes[j] = &(step.dst[8*j+:8] | ~rdRep[8*j+:8]);
		end
		unique case (maskSrc)
			MSK_ONE, MSK_RSV: useFg = 8'hFF;
			MSK_CPU: useFg = pixToLane(cpuBuf_ff[7:0], step.size);
			MSK_BMP: useFg = grpAll(allOnes, step.size);
		endcase
		// raster sources: host or bitmap, mono bits expand through fg/bg
		srcColor = step.srcCpu ? cpuBuf_ff : step.bmpSrc;
		srcData = step.srcMono ? laneSel(pixToLane(srcColor[7:0],
			step.size), fgRep, bgRep) : srcColor;
		patData = step.patMono ? laneSel(pixToLane(step.pat[7:0],
			step.size), fgRep, bgRep) : step.pat;
		colorCpu = !step.rop && (fgMix.src == SRC_CPU ||
			(maskSrc[1] && bgMix.src == SRC_CPU));
		// host colour needs a full 64-bit word, host mask bits only one
		if (colorCpu || (step.rop && step.srcCpu && !step.srcMono)) begin
			needWords = XFER_WORDS;
		end else if ((!step.rop && maskSrc == MSK_CPU) ||
			(step.rop && step.srcCpu)) begin
			needWords = MASK_WORDS;
		end else begin
			needWords = 3'h0;
		end
		dataOk = cpuWords_ff >= needWords;
		// the done cycle blocks a retake while the engine drops its request
		take = stepValid && dataOk && !stepDone_ff;
	end

	genvar i;
	for (i = 0; i < 8; i++) begin : g_clip
		logic [12:0] px;
		assign px = {1'b0, step.x} + 13'(i);
		assign clipPix[i] = misc_ff[EXT_CLIP_BIT] ^ (px >= {1'b0, clipLeft_ff}
			&& px <= {1'b0, clipRight_ff} && step.y >= clipTop_ff
			&& step.y <= clipBot_ff);
	end
	assign clipLane = pixToLane(clipPix, step.size);

	mix_unit u_mix(
		.rop(step.rop),
		.ropCode(ropMix_ff),
		.fgMix(fgMix),
		.bgMix(bgMix),
		.useFg(useFg),
		.fgRep(fgRep),
		.bgRep(bgRep),
		.cpuData(cpuBuf_ff),
		.srcData(srcData),
		.patData(patData),
		.dst(step.dst),
		.newColor(newColor)
	);

	pixel_gate u_gate(
		.size(step.size),
		.newColor(newColor),
		.cmpRep(cmpRep),
		.wrRep(wrRep),
		.cmpEn(misc_ff[CMP_EN_BIT]),
		.cmpSense(misc_ff[CMP_SENSE_BIT]),
		.clipOk(clipLane),
		.bitEn(bitEn)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_cpuBuf = cpuBuf_ff;
		nxt_cpuWords = cpuWords_ff;
		if (take && needWords != 3'h0) begin
			// a word landing in the consuming cycle starts the next buffer
			nxt_cpuWords = 3'h0;
			if (ioWr && isXfer(ioAddr)) begin
				nxt_cpuBuf[15:0] = ioWrData;
				nxt_cpuWords = 3'h1;
			end
		end else if (ioWr && isXfer(ioAddr) && cpuWords_ff < XFER_WORDS) begin
			nxt_cpuBuf[16*cpuWords_ff[1:0]+:16] = ioWrData;
			nxt_cpuWords = cpuWords_ff + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cpuBuf_ff <= 64'h0000_0000_0000_0000;
			cpuWords_ff <= 3'h0;
			xferFull_ff <= 1'b0;
			stepDone_ff <= 1'b0;
			memValid_ff <= 1'b0;
			memData_ff <= 64'h0000_0000_0000_0000;
			memBitEn_ff <= 64'h0000_0000_0000_0000;
		end else begin
			cpuBuf_ff <= nxt_cpuBuf;
			cpuWords_ff <= nxt_cpuWords;
			xferFull_ff <= nxt_cpuWords == XFER_WORDS;
			stepDone_ff <= take;
			memValid_ff <= take;
			memData_ff <= take ? newColor : memData_ff;
			memBitEn_ff <= take ? bitEn : 64'h0000_0000_0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_stall;
		@(posedge clk) disable iff (!resetn)
		stepValid && !dataOk |=> !stepDone_ff && !memValid_ff;
	endproperty
	a_stall: assert property (p_stall) else $error("step taken early");

	property p_host_only;
		@(posedge clk) disable iff (!resetn)
		ioWr && !isXfer(ioAddr) && !take |=> $stable(cpuWords_ff);
	endproperty
	a_host_only: assert property (p_host_only) else $error("buffer moved");

	property p_mask_consume;
		@(posedge clk) disable iff (!resetn)
		take && needWords != 3'h0 |=> cpuWords_ff <= 3'h1;
	endproperty
	a_mask_consume: assert property (p_mask_consume) else $error("not used");

	property p_cmp_off;
		@(posedge clk) disable iff (!resetn)
		take && !misc_ff[CMP_EN_BIT] && clipLane[0]
		|=> memBitEn_ff[7:0] == $past(wrRep[7:0]);
	endproperty
	a_cmp_off: assert property (p_cmp_off) else $error("lost update");

	property p_wr_mask;
		@(posedge clk) disable iff (!resetn)
		take |=> (memBitEn_ff & ~$past(wrRep)) == 64'h0000_0000_0000_0000;
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("masked write");

	property p_match;
		@(posedge clk) disable iff (!resetn)
		take && step.size == PIX8 && misc_ff[CMP_EN_BIT]
		&& misc_ff[CMP_SENSE_BIT] && newColor[7:0] != cmpColor_ff[7:0]
		|=> memBitEn_ff[7:0] == 8'h00;
	endproperty
	a_match: assert property (p_match) else $error("mismatch wrote");

	property p_differ;
		@(posedge clk) disable iff (!resetn)
		take && step.size == PIX8 && misc_ff[CMP_EN_BIT]
		&& !misc_ff[CMP_SENSE_BIT] && newColor[7:0] == cmpColor_ff[7:0]
		|=> memBitEn_ff[7:0] == 8'h00;
	endproperty
	a_differ: assert property (p_differ) else $error("match wrote");

	property p_new_fg;
		@(posedge clk) disable iff (!resetn)
		take && !step.rop && maskSrc == MSK_ONE && fgMix.op == MIX_NEW
		&& fgMix.src == SRC_FG |=> memData_ff == $past(fgRep);
	endproperty
	a_new_fg: assert property (p_new_fg) else $error("bad colour");

	property p_clip;
		@(posedge clk) disable iff (!resetn)
		take && !clipLane[0] ##1 1'b1 |-> memBitEn_ff[7:0] == 8'h00;
	endproperty
	a_clip: assert property (p_clip) else $error("clipped write");
endmodule

// file: pixel_update_mix_unit_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
	end \
end
module pixel_update_mix_unit_tb;
	import pixel_mix_pkg::*;
	logic clk;
	logic resetn;
	wire logic [15:0] ioAddr;
	wire logic [15:0] ioWrData;
	wire logic ioWr;
	wire logic ioRd;
	logic [15:0] ioRdData_ff;
	step_type stp;
	logic stepValid;
	logic stepDone_ff;
	logic memValid_ff;
	logic [63:0] memData_ff;
	logic [63:0] memBitEn_ff;
	logic xferFull_ff;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [15:0] ca [4];
	logic [15:0] mx [3];
	logic [63:0] ex [3];
	logic [7:0] rc [5];
	logic [63:0] re [5];

	pixel_update_mix_unit u_pixel_update_mix_unit(
		.clk(clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrData(ioWrData),
		.ioWr(ioWr), .ioRd(ioRd), .ioRdData_ff(ioRdData_ff), .step(stp),
		.stepValid(stepValid), .stepDone_ff(stepDone_ff),
		.memValid_ff(memValid_ff), .memData_ff(memData_ff),
		.memBitEn_ff(memBitEn_ff), .xferFull_ff(xferFull_ff)
	);
	host_cpu_model u_host_cpu_model(
		.clk(clk), .ioRdData_ff(ioRdData_ff), .ioAddr(ioAddr),
		.ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_host_cpu_model.wr(a, d);
	endtask

	task automatic chkRd(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host_cpu_model.rd(a, d);
		`CHK(d, e)
	endtask

	// stepValid held until the done cycle, then dropped
	task automatic go(input logic [63:0] ed, input logic [63:0] ee);
		int n;
		n = 0;
		@(negedge clk);
		stepValid = 1'b1;
		while (stepDone_ff !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		stepValid = 1'b0;
		`CHK(memValid_ff, 1'b1)
		`CHK(memData_ff, ed)
		`CHK(memBitEn_ff, ee)
		@(negedge clk);
		`CHK(memBitEn_ff, 64'h0000_0000_0000_0000)
	endtask

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#200_000;
		n_mismatch++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		stp = '0;
		stepValid = 1'b0;
		resetn = 1'b0;
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		chkRd(FG_COLOR_ADDR, REG_RESET);
		chkRd(WR_MASK_ADDR, ALL_PLANES);
		chkRd(RD_MASK_ADDR, ALL_PLANES);
		chkRd(MULTI_ADDR, REG_RESET);
		chkRd(XFER_LO_ADDR, REG_RESET);
		chkRd(16'h1234, REG_RESET);
		ca = '{BG_COLOR_ADDR, FG_COLOR_ADDR, WR_MASK_ADDR, CMP_COLOR_ADDR};
		foreach (ca[i]) begin
			wr(ca[i], 16'hA5C3);
			chkRd(ca[i], 16'hA5C3);
		end
		wr(BG_MIX_ADDR, 16'h0065);
		chkRd(BG_MIX_ADDR, 16'h0065);
		wr(FG_COLOR_ADDR, 16'h0002);
		wr(BG_COLOR_ADDR, 16'h0004);
		wr(WR_MASK_ADDR, ALL_PLANES);
		wr(FG_MIX_ADDR, 16'h0027);
		wr(BG_MIX_ADDR, 16'h0007);
		wr(MULTI_ADDR, 16'hA000);
		go({8{8'h02}}, '1);
		wr(FG_COLOR_ADDR, 16'h1234);
		stp.size = PIX16;
		go({4{16'h1234}}, '1);
		stp.size = PIX32;
		// 32-bit pixels see the 16-bit write mask zero-extended
		go({2{32'h0000_1234}}, {2{32'h0000_FFFF}});
		stp.size = PIX8;
		wr(FG_COLOR_ADDR, 16'h0002);
		wr(WR_MASK_ADDR, 16'h000F);
		go({8{8'h02}}, {8{8'h0F}});
		wr(WR_MASK_ADDR, ALL_PLANES);
		// compare: sense 0 rejects equal, sense 1 passes equal
		wr(CMP_COLOR_ADDR, 16'h0002);
		wr(MULTI_ADDR, 16'hE100);
		go({8{8'h02}}, '0);
		wr(MULTI_ADDR, 16'hE180);
		go({8{8'h02}}, '1);
		wr(FG_COLOR_ADDR, 16'h0003);
		stp.dst = {8{8'h02}};
		go({8{8'h03}}, '0);
		wr(FG_COLOR_ADDR, 16'h0002);
		wr(MULTI_ADDR, 16'hE000);
		stp.dst = 64'h0011_2233_4455_6677;
		mx = '{16'h0007, 16'h0027, 16'h0067};
		ex = '{{8{8'h04}}, {8{8'h02}}, 64'h0011_2233_4455_6677};
		for (int i = 0; i < 3; i++) begin
			wr(FG_MIX_ADDR, mx[i]);
			go(ex[i], '1);
		end
		// host colour, mask stays always one so host is not both sources
		wr(FG_MIX_ADDR, 16'h0047);
		// a fifth word is refused while the buffer is full
		for (int i = 0; i < 5; i++) begin
			wr(i[0] ? XFER_HI_ADDR : XFER_LO_ADDR, 16'(i + 1) * 16'h1111);
		end
		`CHK(xferFull_ff, 1'b1)
		go(64'h4444_3333_2222_1111, '1);
		`CHK(xferFull_ff, 1'b0)
		wr(FG_COLOR_ADDR, 16'h000F);
		wr(FG_MIX_ADDR, 16'h0025);
		stp.dst = {8{8'h33}};
		go({8{8'h3C}}, '1);
		wr(FG_COLOR_ADDR, 16'h0002);
		wr(FG_MIX_ADDR, 16'h0027);
		// host mask bits: the step must wait for them
		wr(MULTI_ADDR, 16'hA080);
		@(negedge clk);
		stepValid = 1'b1;
		repeat (4) begin
			@(negedge clk);
			`CHK(stepDone_ff, 1'b0)
		end
		stepValid = 1'b0;
		wr(XFER_LO_ADDR, 16'h00A5);
		go(64'h0204_0204_0402_0402, '1);
		wr(MULTI_ADDR, 16'hA0C0);
		stp.dst = 64'hFF7F_FF7F_FFFF_0000;
		go(64'h0204_0204_0202_0404, '1);
		// only read-enabled planes take part in the all-ones test
		wr(RD_MASK_ADDR, 16'h007F);
		go(64'h0202_0202_0202_0404, '1);
		wr(RD_MASK_ADDR, ALL_PLANES);
		wr(MULTI_ADDR, 16'hA000);
		wr(MULTI_ADDR, 16'h4003);
		go({8{8'h02}}, 64'h0000_0000_FFFF_FFFF);
		wr(MULTI_ADDR, 16'hE020);
		go({8{8'h02}}, 64'hFFFF_FFFF_0000_0000);
		wr(MULTI_ADDR, 16'hE000);
		wr(MULTI_ADDR, 16'h4FFF);
		// raster ops with a bitmap source, so no code waits for host words
		stp.rop = 1'b1;
		stp.bmpSrc = 64'h0123_4567_89AB_CDEF;
		stp.pat = 64'hF0F0_0F0F_FF00_00FF;
		stp.dst = {8{8'h33}};
		rc = '{8'hF0, 8'hCC, 8'hAA, 8'h55, 8'h66};
		re = '{stp.pat, stp.bmpSrc, stp.dst, ~stp.dst, stp.bmpSrc ^ stp.dst};
		for (int i = 0; i < 5; i++) begin
			wr(ROP_MIX_ADDR, {8'h00, rc[i]});
			go(re[i], '1);
		end
		stp.patMono = 1'b1;
		stp.pat = 64'h0000_0000_0000_000F;
		wr(ROP_MIX_ADDR, 16'h00F0);
		go(64'h0404_0404_0202_0202, '1);
		// host source: mono needs one word, colour needs four
		stp.srcCpu = 1'b1;
		stp.srcMono = 1'b1;
		wr(ROP_MIX_ADDR, 16'h00CC);
		wr(XFER_LO_ADDR, 16'h00F0);
		go(64'h0202_0202_0404_0404, '1);
		stp.srcMono = 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(XFER_LO_ADDR, 16'(i + 5) * 16'h1111);
		end
		go(64'h8888_7777_6666_5555, '1);
		test_done();
	end
endmodule
